// ---- bench/ccs_gate_model.sv ----
/* gate driver and bootstrap model for the far side.
   assumes active high drives; leak drops the bootstrap node. */
`timescale 1ns/100ps
module ccs_gate_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic leak,
    output logic boot_low,
    output logic [15:0] hs_rises,
    output logic [15:0] ls_len
);
    logic hs_d_q, ls_d_q;
    logic [15:0] run_q;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            {hs_d_q, ls_d_q, boot_low} <= 3'h0;
            {hs_rises, ls_len, run_q} <= '0;
        end
        else
        begin
            hs_d_q <= high_side_drive;
            ls_d_q <= low_side_drive;
            run_q <= low_side_drive ? run_q + 16'h1 : 16'h0;
            if (high_side_drive && !hs_d_q)
                hs_rises <= hs_rises + 16'h1;
            if (!low_side_drive && ls_d_q)
                ls_len <= run_q;
            // node refills only after a whole low pulse
            if (leak)
                boot_low <= 1'b1;
            else if (!low_side_drive && ls_d_q)
                boot_low <= 1'b0;
        end
    end
endmodule

// ---- bench/ccs_seq_props.sv ----
/* checker for the charger sequencer outputs.
   assumes it sees only the top module ports, bound at the foot. */
`timescale 1ns/100ps
module ccs_seq_props #(
    parameter int SS_STEP_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic charge_active,
    input wire logic [3:0] current_ref_step,
    input wire logic high_side_drive,
    input wire logic low_side_drive,
    input wire logic sync_mode,
    input wire logic discharge_sink_en,
    input wire logic thermal_shutdown
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----
    // run lengths
    // ----
    logic [19:0] hs_q, ls_q, gap_q, hold_q;
    logic [3:0] stp_q;
    logic seen_q;
    wire logic rise = high_side_drive && hs_q == 20'h0;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            hs_q <= '0;
            ls_q <= '0;
            gap_q <= '0;
            hold_q <= '0;
            stp_q <= '0;
            seen_q <= 1'b0;
        end
        else if (clk_en)
        begin
            hs_q <= high_side_drive ? hs_q + 20'h1 : 20'h0;
            ls_q <= low_side_drive ? ls_q + 20'h1 : 20'h0;
            gap_q <= rise ? 20'h1 : gap_q + 20'h1;
            seen_q <= charge_active && (seen_q || rise);
            hold_q <= (current_ref_step != stp_q) ? 20'h1 : hold_q + 20'h1;
            stp_q <= current_ref_step;
        end
    end
    // ----
    // properties
    // ----
    AST_NO_OVERLAP: assert property
        (!(high_side_drive && low_side_drive)) else $error("drives overlap");
    AST_DEAD_HL: assert property
        ($fell(high_side_drive) |-> !low_side_drive [*8]) else $error("short dead time");
    AST_DEAD_LH: assert property
        ($fell(low_side_drive) |-> !high_side_drive [*8]) else $error("short dead time");
    AST_HS_CAP: assert property
        (high_side_drive |-> hs_q < ccs_pkg::HS_MAX_ON) else $error("high side too long");
    AST_PERIOD: assert property
        (rise && seen_q |-> gap_q % ccs_pkg::SW_PERIOD_CYC == 0) else $error("bad period");
    AST_RECHG: assert property
        ($fell(low_side_drive) && !sync_mode && !$past(sync_mode, 30) && charge_active
        |-> ls_q == ccs_pkg::RECHG_CYC) else $error("bad low pulse width");
    AST_STEP_INC: assert property
        ($changed(current_ref_step) |-> current_ref_step == $past(current_ref_step) + 4'h1
        || current_ref_step == 4'h0) else $error("step jump");
    AST_STEP_HOLD: assert property
        ($changed(current_ref_step) && $past(current_ref_step) != 4'h0
        && current_ref_step != 4'h0 |-> hold_q == SS_STEP_CYCLES) else $error("step time");
    AST_OFF_IDLE: assert property
        (!charge_active && !$past(charge_active) |-> !high_side_drive && !low_side_drive
        && current_ref_step == 4'h0) else $error("activity while off");
    AST_SINK: assert property
        (discharge_sink_en == charge_active) else $error("sink mismatch");
    AST_THERM: assert property
        (thermal_shutdown [*3] |-> !charge_active) else $error("charging while hot");
    COV_START: cover property ($rose(charge_active));
    COV_PULSE: cover property ($fell(low_side_drive) && !sync_mode);
    COV_HOT: cover property ($rose(thermal_shutdown));
    COV_FULL: cover property (current_ref_step == 4'h8);
endmodule

bind ccs_charger_seq ccs_seq_props #(.SS_STEP_CYCLES(SS_STEP_CYCLES)) u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .charge_active(charge_active),
    .current_ref_step(current_ref_step), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .sync_mode(sync_mode),
    .discharge_sink_en(discharge_sink_en), .thermal_shutdown(thermal_shutdown));

// ---- bench/tb_top.sv ----
/* self-checking bench for the charger sequencer.
   assumes shortened qualification and step counts, 250 MHz clock. */
`timescale 1ns/100ps
module tb_top;
    localparam int QC = 50;
    localparam int SC = 20;
    localparam int PER = 833;
    typedef struct {int sel; logic [15:0] exp;} ccs_note_s;
    ccs_note_s notes[$];
    ccs_note_s n;
    event chk_ev;
    int num_errors = 0, checks_done = 0, cycles = 0, w;
    int fl [9] = '{11, 10, 7, 6, 5, 4, 1, 3, 2};
    string nm [11] = '{"charge_active", "step", "sink", "monitor", "regulator",
        "reference", "thermal", "sync_mode", "hs_rises", "ls_len", "boot_low"};
    logic ref_clk = 1'b0, rst_n = 1'b0, leak = 1'b0, cen = 1'b1;
    logic [31:0] r;
    logic [15:0] h;
    ccs_pkg::ccs_supply_s sup = 12'h7CD;
    logic [4:0] cnv = 5'h01;
    ccs_pkg::ccs_conv_s conv;
    logic ca, hs, ls, sm, sink, mon, rge, refe, ts, bl;
    logic [3:0] step;
    logic [15:0] rises, lsl;
    assign conv = {cnv[4], bl, cnv[2:0]};
    ccs_charger_seq #(.QUAL_CYCLES(QC), .SS_STEP_CYCLES(SC)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(cen), .supply_in(sup), .conv_in(conv),
        .charge_active(ca), .current_ref_step(step), .high_side_drive(hs),
        .low_side_drive(ls), .sync_mode(sm), .discharge_sink_en(sink),
        .input_current_monitor_en(mon), .gate_drive_regulator_en(rge),
        .reference_en(refe), .thermal_shutdown(ts));
    ccs_gate_model u_drv (.ref_clk(ref_clk), .rst_n(rst_n), .high_side_drive(hs),
        .low_side_drive(ls), .leak(leak), .boot_low(bl), .hs_rises(rises), .ls_len(lsl));
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    // ----
    // helpers
    // ----
    function automatic logic [15:0] obs(int s);
        logic [10:0] b = {bl, 1'b0, 1'b0, sm, ts, refe, rge, mon, sink, 1'b0, ca};
        if (s == 1)
            return {12'h0, step};
        if (s == 8)
            return rises;
        if (s == 9)
            return lsl;
        return {15'h0, b[s]};
    endfunction
    task automatic cyc(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(int s, logic [15:0] e);
        notes.push_back('{s, e});
        -> chk_ev;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(chk_ev)
    begin
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            checks_done++;
            if (obs(n.sel) !== n.exp)
            begin
                num_errors++;
                $display("CHECK FAILED %s expected %0h seen %0h", nm[n.sel], n.exp, obs(n.sel));
            end
        end
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    // ----
    // scenarios
    // ----
    initial
    begin
        void'($urandom(38147));
        cyc(3);
        for (w = 0; w < 8; w++)
            chk(w, 16'h0);
        rst_n = 1'b1;
        cyc(20);
        chk(0, 16'h0);
        sup[11] = 1'b1;
        repeat (8)
        begin
            r = $urandom;
            sup[10:8] = r[2:0];
            cyc(5);
            chk(3, {15'h0, r[1] & r[0]});
            chk(4, {15'h0, r[2] & r[0]});
            chk(5, {15'h0, r[2] & r[0]});
        end
        sup = 12'h7CD;
        cyc(QC + 8 * SC + 40);
        chk(0, 16'h1);
        chk(2, 16'h1);
        cen = 1'b0;
        sup[11] = 1'b1;
        cyc(10);
        chk(0, 16'h1);
        cen = 1'b1;
        cyc(8);
        chk(0, 16'h0);
        sup = 12'h7CD;
        cyc(QC + 8 * SC + 40);
        chk(1, 16'h8);
        foreach (fl[i])
        begin
            sup[fl[i]] = ~sup[fl[i]];
            cyc(8);
            if (i < 7)
            begin
                chk(0, 16'h0);
                chk(1, 16'h0);
            end
            else
            begin
                sup[11] = 1'b1;
                cyc(4);
                sup[11] = 1'b0;
            end
            cyc(QC + 30);
            chk(0, 16'h0);
            chk(2, 16'h0);
            sup = 12'h7CD;
            cyc(QC + 8 * SC + 40);
            chk(0, 16'h1);
            chk(1, 16'h8);
        end
        chk(8, 16'h0);
        cnv[4] = 1'b1;
        cyc(PER);
        h = rises;
        cyc(3 * PER);
        chk(8, h + 16'h3);
        chk(7, 16'h1);
        cnv[2] = 1'b1;
        cyc(2 * PER);
        chk(7, 16'h0);
        chk(9, 16'h14);
        for (w = 0; w < PER && !ls; w++)
            cyc(1);
        for (w = 0; w < 40 && ls; w++)
            cyc(1);
        leak = 1'b1;
        cyc(1);
        leak = 1'b0;
        h = rises;
        cyc(2);
        for (w = 0; w < 6 * PER && bl; w++)
            cyc(1);
        chk(10, 16'h0);
        chk(8, h);
        chk(9, 16'h14);
        cyc(2 * PER);
        chk(8, h + 16'h2);
        cnv[1:0] = 2'h2;
        cyc(5);
        h = rises;
        cyc(2 * PER);
        chk(8, h);
        cnv[1] = 1'b0;
        cyc(2 * PER);
        chk(8, h);
        cnv[0] = 1'b1;
        cyc(2 * PER);
        chk(8, h + 16'h2);
        sup[4] = 1'b1;
        cyc(5);
        h = rises;
        cyc(2 * PER);
        chk(8, h);
        sup[4] = 1'b0;
        cyc(5 * PER / 2);
        chk(8, h + 16'h2);
        cnv[4] = 1'b0;
        cyc(PER);
        sup[1:0] = 2'h2;
        cyc(6);
        chk(6, 16'h1);
        sup[1] = 1'b0;
        cyc(6);
        chk(6, 16'h1);
        chk(0, 16'h0);
        sup[0] = 1'b1;
        cyc(6);
        chk(6, 16'h0);
        cyc(1);
        end_of_test();
    end
endmodule

// ---- rtl/ccs_charger_seq.sv ----
/*
 * Charger control sequencer: charge qualification, soft-start,
 * fixed-frequency gate-drive timing and protection.
 * Assumes all comparator levels arrive asynchronously on pins.
 */
`timescale 1ns/100ps

// Overview of operation
// R1: charge enables only when every supply, adapter, delay, good and thermal term holds.
// R2: any disable, lockout, adapter fault, overcurrent or thermal trip ends charge.
// R3: thermal trip latches off until temperature falls below release point.
// R4: current reference ramps from low to full in equal steps each enable.
// R5: each step lasts a fixed interval; seven intervals take the ramp from step 1 to full.
// R6: switching period is fixed, independent of all analog conditions.
// R7: zero to near-full duty; high-side never held on continuously.
// R8: bootstrap low over three cycles gives one recharge pulse, then resume.
// R9: non-synchronous below sync threshold, synchronous otherwise.
// R10: synchronous low-side is complementary with dead-time at each edge.
// R11: non-synchronous low-side gives one short pulse after dead-time.
// R12: bootstrap low keeps high-side off; only the recharge pulse on low-side.
// R13: input current monitor grounded until supply and adapter bias are met.
// R14: below lockout gate regulator and reference stay inactive.
// R15: battery overvoltage blocks high-side until below lower ratio.
// R16: battery discharge sink on only while charging.
// R17: overcurrent turns high-side off, resumes when it clears.
// R18: adapter detection starts the post-detect delay.
// R19: all timing from counters; step and all counters but the post-detect delay reset when charge stops.
module ccs_charger_seq #(
    parameter int QUAL_CYCLES = ccs_pkg::QUAL_DELAY_CYC,
    parameter int SS_STEP_CYCLES = ccs_pkg::SS_STEP_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire ccs_pkg::ccs_supply_s supply_in,
    input wire ccs_pkg::ccs_conv_s conv_in,
    output logic charge_active,
    output logic [3:0] current_ref_step,
    output logic high_side_drive,
    output logic low_side_drive,
    output logic sync_mode,
    output logic discharge_sink_en,
    output logic input_current_monitor_en,
    output logic gate_drive_regulator_en,
    output logic reference_en,
    output logic thermal_shutdown
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int SW = $bits(ccs_pkg::ccs_supply_s);
    localparam int CW = $bits(ccs_pkg::ccs_conv_s);

    logic [SW-1:0] sup_meta_q;
    logic [SW-1:0] sup_sync_q;
    logic [CW-1:0] conv_meta_q;
    logic [CW-1:0] conv_sync_q;
    ccs_pkg::ccs_supply_s sup;
    ccs_pkg::ccs_conv_s cnv;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sup_meta_q <= '0;
            sup_sync_q <= '0;
            conv_meta_q <= '0;
            conv_sync_q <= '0;
        end
        else if (clk_en)
        begin
            sup_meta_q <= supply_in;
            sup_sync_q <= sup_meta_q;
            conv_meta_q <= conv_in;
            conv_sync_q <= conv_meta_q;
        end
    end

    assign sup = ccs_pkg::ccs_supply_s'(sup_sync_q);
    assign cnv = ccs_pkg::ccs_conv_s'(conv_sync_q);

    // ------------------------------------------------------------
    // thermal hysteresis
    // ------------------------------------------------------------
    logic therm_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            therm_q <= 1'b0;
        else if (clk_en)
        begin
            if (sup.temp_above_trip)
                therm_q <= 1'b1; // R3
            else if (sup.temp_below_release)
                therm_q <= 1'b0; // R3
        end
    end

    // ------------------------------------------------------------
    // charge qualification
    // ------------------------------------------------------------
    logic adapter_ok;
    logic stop_cond;
    logic start_cond;
    logic [ccs_pkg::CNT_W-1:0] qual_cnt_q;
    logic [ccs_pkg::CNT_W-1:0] ss_cnt_q;
    logic [3:0] step_q;
    ccs_pkg::ccs_state_e state_q;
    logic qual_done;

    assign adapter_ok = sup.supply_above_lockout && sup.adapter_valid
                        && sup.adapter_above_bat && !sup.adapter_ovp;
    // R2
    assign stop_cond = sup.charge_disable_input || !sup.supply_above_lockout
                       || !sup.adapter_valid || !sup.adapter_above_bat
                       || sup.adapter_ovp || sup.adapter_ocp || therm_q;
    // R1
    assign start_cond = !sup.charge_disable_input && adapter_ok && qual_done
                        && sup.gate_regulator_good && sup.reference_good
                        && !therm_q && !sup.adapter_ocp;
    assign qual_done = (qual_cnt_q >= ccs_pkg::CNT_W'(QUAL_CYCLES));

    // post-detect delay runs while an adapter stays detected and supply is above lockout
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            qual_cnt_q <= '0;
        else if (clk_en)
        begin
            if (!sup.adapter_valid || !sup.supply_above_lockout)
                qual_cnt_q <= '0; // R18
            else if (!qual_done)
                qual_cnt_q <= qual_cnt_q + 1'b1; // R18
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            state_q <= ccs_pkg::CCS_OFF;
        else if (clk_en)
        begin
            case (state_q)
                ccs_pkg::CCS_OFF:
                    if (start_cond)
                        state_q <= ccs_pkg::CCS_CHARGE; // R1
                ccs_pkg::CCS_QUAL:
                    state_q <= ccs_pkg::CCS_OFF;
                ccs_pkg::CCS_CHARGE:
                    if (stop_cond)
                        state_q <= ccs_pkg::CCS_OFF; // R2
                default:
                    state_q <= ccs_pkg::CCS_OFF;
            endcase
        end
    end

    logic charging;
    assign charging = (state_q == ccs_pkg::CCS_CHARGE);

    // ------------------------------------------------------------
    // soft-start
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            ss_cnt_q <= '0;
            step_q <= '0;
        end
        else if (clk_en)
        begin
            if (!charging)
            begin
                ss_cnt_q <= '0; // R19
                step_q <= '0; // R19
            end
            else if (step_q == '0)
                step_q <= 4'h1; // R4
            else if (step_q != ccs_pkg::SS_FULL)
            begin
                if (ss_cnt_q >= ccs_pkg::CNT_W'(SS_STEP_CYCLES - 1))
                begin
                    ss_cnt_q <= '0;
                    step_q <= step_q + 4'h1; // R4 R5
                end
                else
                    ss_cnt_q <= ss_cnt_q + 1'b1; // R5
            end
        end
    end

    // ------------------------------------------------------------
    // switching timing
    // ------------------------------------------------------------
    logic [ccs_pkg::PER_W-1:0] per_q;
    logic [ccs_pkg::PER_W-1:0] ph_cnt_q;
    ccs_pkg::ccs_phase_e phase_q;
    logic cycle_start;
    logic ovp_q;
    logic [1:0] boot_cnt_q;
    logic boot_rechg_q;
    logic hs_allow;

    assign cycle_start = (per_q == ccs_pkg::PER_LAST);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            per_q <= '0;
        else if (clk_en)
        begin
            if (!charging || cycle_start)
                per_q <= '0; // R6 R19
            else
                per_q <= per_q + 1'b1; // R6
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ovp_q <= 1'b0;
        else if (clk_en)
        begin
            if (cnv.bat_above_high_ovp)
                ovp_q <= 1'b1; // R15
            else if (cnv.bat_below_low_ovp)
                ovp_q <= 1'b0; // R15
        end
    end

    // count consecutive cycles with low bootstrap
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            boot_cnt_q <= '0;
            boot_rechg_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!charging || !cnv.bootstrap_low)
            begin
                boot_cnt_q <= '0;
                boot_rechg_q <= 1'b0;
            end
            else if (cycle_start)
            begin
                if (boot_cnt_q == ccs_pkg::BOOT_LIMIT)
                begin
                    boot_rechg_q <= 1'b1; // R8
                    boot_cnt_q <= '0; // R8
                end
                else
                begin
                    boot_cnt_q <= boot_cnt_q + 2'h1;
                    boot_rechg_q <= 1'b0;
                end
            end
        end
    end

    // R12 R15 R17
    assign hs_allow = charging && !cnv.bootstrap_low && !ovp_q && !sup.adapter_ocp;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            phase_q <= ccs_pkg::CCS_PH_IDLE;
            ph_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            ph_cnt_q <= ph_cnt_q + 1'b1;
            if (!charging)
            begin
                phase_q <= ccs_pkg::CCS_PH_IDLE; // R19
                ph_cnt_q <= '0;
            end
            else if (cycle_start)
            begin
                ph_cnt_q <= '0;
                if (hs_allow && cnv.pwm_request)
                    phase_q <= ccs_pkg::CCS_PH_HIGH; // R7
                else if (boot_rechg_q || (cnv.bootstrap_low && boot_cnt_q == ccs_pkg::BOOT_LIMIT))
                    phase_q <= ccs_pkg::CCS_PH_DEAD1; // R8 R12
                else
                    phase_q <= ccs_pkg::CCS_PH_IDLE; // R7
            end
            else
            begin
                case (phase_q)
                    ccs_pkg::CCS_PH_HIGH:
                        if (!hs_allow || !cnv.pwm_request
                            || ph_cnt_q >= ccs_pkg::HS_MAX_ON - 1'b1)
                        begin
                            phase_q <= ccs_pkg::CCS_PH_DEAD1; // R7 R15 R17
                            ph_cnt_q <= '0;
                        end
                    ccs_pkg::CCS_PH_DEAD1:
                        if (ph_cnt_q >= ccs_pkg::DEAD_LEN - 1'b1)
                        begin
                            ph_cnt_q <= '0;
                            if (cnv.below_sync_threshold || cnv.bootstrap_low)
                                phase_q <= ccs_pkg::CCS_PH_RECHG; // R9 R11 R12
                            else
                                phase_q <= ccs_pkg::CCS_PH_LOW; // R9 R10
                        end
                    ccs_pkg::CCS_PH_LOW:
                        if (per_q >= ccs_pkg::PER_LAST - ccs_pkg::DEAD_LEN)
                            phase_q <= ccs_pkg::CCS_PH_IDLE; // R10
                    ccs_pkg::CCS_PH_RECHG:
                        if (ph_cnt_q >= ccs_pkg::RECHG_LEN - 1'b1)
                            phase_q <= ccs_pkg::CCS_PH_IDLE; // R11
                    ccs_pkg::CCS_PH_IDLE:
                        phase_q <= ccs_pkg::CCS_PH_IDLE;
                    default:
                        phase_q <= ccs_pkg::CCS_PH_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            high_side_drive <= 1'b0;
            low_side_drive <= 1'b0;
            sync_mode <= 1'b0;
        end
        else if (clk_en)
        begin
            high_side_drive <= (phase_q == ccs_pkg::CCS_PH_HIGH) && hs_allow; // R10 R15 R17
            low_side_drive <= (phase_q == ccs_pkg::CCS_PH_LOW)
                              || (phase_q == ccs_pkg::CCS_PH_RECHG); // R10 R11
            sync_mode <= !cnv.below_sync_threshold; // R9
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            charge_active <= 1'b0;
            current_ref_step <= '0;
            discharge_sink_en <= 1'b0;
            input_current_monitor_en <= 1'b0;
            gate_drive_regulator_en <= 1'b0;
            reference_en <= 1'b0;
            thermal_shutdown <= 1'b0;
        end
        else if (clk_en)
        begin
            charge_active <= charging;
            current_ref_step <= step_q; // R4
            discharge_sink_en <= charging; // R16
            input_current_monitor_en <= sup.supply_above_csa && sup.adapter_bias; // R13
            gate_drive_regulator_en <= sup.supply_above_lockout && sup.adapter_bias; // R14
            reference_en <= sup.supply_above_lockout && sup.adapter_bias; // R14
            thermal_shutdown <= therm_q; // R3
        end
    end

endmodule

// ---- rtl/ccs_pkg.sv ----
/*
 * Constants and carrier types for the charger control sequencer.
 * Assumes a 250 MHz ref_clk; all comparator inputs are digital levels.
 */
package ccs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int QUAL_DELAY_MS = 1200;
    localparam int QUAL_DELAY_CYC = QUAL_DELAY_MS * 1000 * CLK_MHZ;
    localparam int SS_STEP_US = 1700;
    localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
    localparam int SW_FREQ_KHZ = 300;
    // longest period that fits: round down
    localparam int SW_PERIOD_CYC = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
    localparam int DEAD_NS = 30;
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int RECHG_NS = 80;
    localparam int RECHG_CYC = (RECHG_NS * CLK_MHZ + 999) / 1000;
    localparam int BOOT_LOW_CYCLES = 3;
    localparam int SS_STEPS = 8;

    localparam int CNT_W = 32;
    localparam int PER_W = 10;
    localparam int SS_W = 4;
    localparam logic [PER_W-1:0] PER_LAST = PER_W'(SW_PERIOD_CYC - 1);
    localparam logic [PER_W-1:0] DEAD_LEN = PER_W'(DEAD_CYC);
    localparam logic [PER_W-1:0] RECHG_LEN = PER_W'(RECHG_CYC);
    // high-side must leave room for two dead-times plus recharge pulse
    localparam logic [PER_W-1:0] HS_MAX_ON = PER_W'(SW_PERIOD_CYC - DEAD_CYC - RECHG_CYC - DEAD_CYC);
    localparam logic [SS_W-1:0] SS_FULL = SS_W'(SS_STEPS);
    localparam logic [1:0] BOOT_LIMIT = 2'(BOOT_LOW_CYCLES);

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic charge_disable_input;
        logic supply_above_lockout;
        logic supply_above_csa;
        logic adapter_bias;
        logic adapter_valid;
        logic adapter_above_bat;
        logic adapter_ovp;
        logic adapter_ocp;
        logic gate_regulator_good;
        logic reference_good;
        logic temp_above_trip;
        logic temp_below_release;
    } ccs_supply_s;

    typedef struct packed {
        logic pwm_request;
        logic bootstrap_low;
        logic below_sync_threshold;
        logic bat_above_high_ovp;
        logic bat_below_low_ovp;
    } ccs_conv_s;

    typedef enum {
        CCS_OFF,
        CCS_QUAL,
        CCS_CHARGE
    } ccs_state_e;

    typedef enum {
        CCS_PH_HIGH,
        CCS_PH_DEAD1,
        CCS_PH_LOW,
        CCS_PH_RECHG,
        CCS_PH_IDLE
    } ccs_phase_e;

endpackage
